// >>> prro_map.vh
// register offsets, field positions, reset values and timing counts of the relay output block
`ifndef PRRO_MAP_VH
`define PRRO_MAP_VH
`define PRRO_ADDR_CTRL        8'h00
`define PRRO_ADDR_DELAY       8'h04
`define PRRO_ADDR_STATUS      8'h08
`define PRRO_ADDR_ELAPSED     8'h0C
`define PRRO_SEL_W            5
`define PRRO_SEL_RESET        5'h07
`define PRRO_SEL_MAX          5'h13
`define PRRO_SEL_INVERT_MIN   5'h0A
`define PRRO_DELAY_W          10
`define PRRO_DELAY_RESET      10'h000
`define PRRO_DELAY_MAX        10'h3E7
`define PRRO_CLOCK_HZ         200000000
`define PRRO_TICK_S           1
`define PRRO_TICK_CYCLES      28'h0BEB_C200
`define PRRO_HOLD_S           1
`define PRRO_PRE_W            28
`define PRRO_ST_IDLE          2'h0
`define PRRO_ST_DELAY         2'h1
`define PRRO_ST_ACTIVE        2'h2
`define PRRO_ST_HOLD          2'h3
`define PRRO_STAT_RELAY       0
`define PRRO_STAT_ACTIVE      1
`define PRRO_STAT_TIMED       2
`define PRRO_STAT_REJECT      3
`define PRRO_STAT_ST_LSB      4
`endif

// >>> prro_tick.v
// one-second prescaler for the relay delay counter
`timescale 1ns/10ps
`include "prro_map.vh"
module prro_tick #(
  parameter [27:0] TICK_CYCLES = `PRRO_TICK_CYCLES
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        ce,
  input  wire        restart,
  output reg         tick
);
  reg [`PRRO_PRE_W-1:0] count;

  always @(posedge clock) begin
    if (rst) begin
      count <= {`PRRO_PRE_W{1'b0}};
      tick  <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        count <= {`PRRO_PRE_W{1'b0}};
        tick  <= 1'b0;
      end else if (count == TICK_CYCLES - 28'd1) begin
        count <= {`PRRO_PRE_W{1'b0}};
        tick  <= 1'b1;
      end else begin
        count <= count + 28'd1;
        tick  <= 1'b0;
      end
    end
  end
endmodule

// >>> prro_event.v
// state decode and event edge detection for the relay output block
`timescale 1ns/10ps
`include "prro_map.vh"
module prro_event (
  input  wire        clock,
  input  wire        rst,
  input  wire        ce,
  input  wire [3:0]  fault_code,
  input  wire        fault_active,
  input  wire        is_ready,
  input  wire        is_starting,
  input  wire        is_bypass,
  input  wire        start_cmd,
  input  wire        stop_cmd,
  input  wire        stop_done,
  output wire        motor_fault,
  output wire        running,
  output wire [4:0]  events
);
  reg [4:0] prev;
  wire [4:0] raw;

  // only motor fault codes 05 06 07 08 12 15 count
  assign motor_fault = fault_active & ((fault_code >= 4'h5 && fault_code <= 4'h8) |
                       (fault_code == 4'hC) | (fault_code == 4'hF));
  assign running = ~is_ready & ~fault_active;
  assign raw     = {stop_done, stop_cmd, is_bypass, is_starting, start_cmd};
  assign events  = raw & ~prev;

  always @(posedge clock) begin
    if (rst) begin
      prev <= 5'h1F;
    end else if (ce) begin
      prev <= raw;
    end
  end
endmodule

// >>> prro_top.v
// programmable relay output controller with wishbone register access
`timescale 1ns/10ps
`include "prro_map.vh"
// Behaviour
// - selections 0-4 and 10-14 are timed
// - selection picks start ramp bypass stop done
// - delay counter up to 999 seconds
// - nonzero delay toggles after full delay only for start, up to one second sooner for other events
// - zero delay toggles on the event
// - hold one second after delay when ready
// - new start restarts the timed sequence
// - selections 5-9 and 15-19 show state
// - state mode ignores the delay setting
// - selection resets to ready indication
// - fault only for listed motor codes
// - running means neither ready nor faulted
// - selection above 9 inverts relay sense
// - selection values above 19 are rejected
module prro_top #(
  parameter [27:0] TICK_CYCLES = `PRRO_TICK_CYCLES
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        ce,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [3:0]  fault_code,
  input  wire        fault_active,
  input  wire        is_ready,
  input  wire        is_starting,
  input  wire        is_bypass,
  input  wire        start_cmd,
  input  wire        stop_cmd,
  input  wire        stop_done,
  output reg         relay_out
);
  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  reg [`PRRO_SEL_W-1:0]   output_function_select;
  reg [`PRRO_DELAY_W-1:0] output_delay_setting;
  reg                     reject;
  reg [1:0]               state;
  reg [1:0]               next_state;
  reg [`PRRO_DELAY_W-1:0] elapsed;
  reg [`PRRO_DELAY_W-1:0] next_elapsed;
  reg                     active;
  reg                     next_active;
  reg                     level;
  wire                    tick;
  wire                    motor_fault;
  wire                    running;
  wire [4:0]              events;
  reg                     timed;
  reg                     invert;
  reg  [2:0]              item;
  wire                    trig;
  wire                    restart;
  wire                    access;
  wire [`PRRO_SEL_W-1:0]  sel_in;
  wire [`PRRO_DELAY_W-1:0] dly_in;
  reg                     state_level;

  assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign sel_in  = wb_dat_i[`PRRO_SEL_W-1:0];
  assign dly_in  = wb_dat_i[`PRRO_DELAY_W-1:0];
  assign trig    = (item < 3'd5) ? events[item] : 1'b0;
  assign restart = events[0];

  // ---------------------------------------------------------------
  // selection decode
  // ---------------------------------------------------------------
  always @* begin
    case (output_function_select)
      5'h00: begin
        timed  = 1'b1;
        invert = 1'b0;
        item   = 3'h0;
      end
      5'h01: begin
        timed  = 1'b1;
        invert = 1'b0;
        item   = 3'h1;
      end
      5'h02: begin
        timed  = 1'b1;
        invert = 1'b0;
        item   = 3'h2;
      end
      5'h03: begin
        timed  = 1'b1;
        invert = 1'b0;
        item   = 3'h3;
      end
      5'h04: begin
        timed  = 1'b1;
        invert = 1'b0;
        item   = 3'h4;
      end
      5'h05: begin
        timed  = 1'b0;
        invert = 1'b0;
        item   = 3'h5;
      end
      5'h06: begin
        timed  = 1'b0;
        invert = 1'b0;
        item   = 3'h6;
      end
      5'h07: begin
        timed  = 1'b0;
        invert = 1'b0;
        item   = 3'h7;
      end
      5'h08: begin
        timed  = 1'b0;
        invert = 1'b0;
        item   = 3'h0;
      end
      5'h09: begin
        timed  = 1'b0;
        invert = 1'b0;
        item   = 3'h1;
      end
      5'h0A: begin
        timed  = 1'b1;
        invert = 1'b1;
        item   = 3'h0;
      end
      5'h0B: begin
        timed  = 1'b1;
        invert = 1'b1;
        item   = 3'h1;
      end
      5'h0C: begin
        timed  = 1'b1;
        invert = 1'b1;
        item   = 3'h2;
      end
      5'h0D: begin
        timed  = 1'b1;
        invert = 1'b1;
        item   = 3'h3;
      end
      5'h0E: begin
        timed  = 1'b1;
        invert = 1'b1;
        item   = 3'h4;
      end
      5'h0F: begin
        timed  = 1'b0;
        invert = 1'b1;
        item   = 3'h5;
      end
      5'h10: begin
        timed  = 1'b0;
        invert = 1'b1;
        item   = 3'h6;
      end
      5'h11: begin
        timed  = 1'b0;
        invert = 1'b1;
        item   = 3'h7;
      end
      5'h12: begin
        timed  = 1'b0;
        invert = 1'b1;
        item   = 3'h0;
      end
      5'h13: begin
        timed  = 1'b0;
        invert = 1'b1;
        item   = 3'h1;
      end
      default: begin
        timed  = 1'b0;
        invert = 1'b0;
        item   = 3'h2;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sub blocks
  // ---------------------------------------------------------------
  prro_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock   (clock),
    .rst     (rst),
    .ce      (ce),
    .restart (restart),
    .tick    (tick)
  );

  prro_event u_event (
    .clock        (clock),
    .rst          (rst),
    .ce           (ce),
    .fault_code   (fault_code),
    .fault_active (fault_active),
    .is_ready     (is_ready),
    .is_starting  (is_starting),
    .is_bypass    (is_bypass),
    .start_cmd    (start_cmd),
    .stop_cmd     (stop_cmd),
    .stop_done    (stop_done),
    .motor_fault  (motor_fault),
    .running      (running),
    .events       (events)
  );

  // ---------------------------------------------------------------
  // state indication
  // ---------------------------------------------------------------
  always @* begin
    case (item)
      3'd5:    state_level = motor_fault;
      3'd6:    state_level = running;
      3'd7:    state_level = is_ready;
      3'd0:    state_level = is_starting;
      3'd1:    state_level = is_bypass;
      default: state_level = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // timed sequence
  // ---------------------------------------------------------------
  always @* begin
    next_state   = state;
    next_elapsed = elapsed;
    next_active  = active;
    if (restart && timed) begin
      next_state   = `PRRO_ST_IDLE;
      next_elapsed = {`PRRO_DELAY_W{1'b0}};
      next_active  = 1'b0;
    end
    case (next_state)
      `PRRO_ST_IDLE: begin
        if (timed && trig) begin
          next_elapsed = {`PRRO_DELAY_W{1'b0}};
          if (output_delay_setting == `PRRO_DELAY_RESET) begin
            next_active = 1'b1;
            next_state  = `PRRO_ST_ACTIVE;
          end else begin
            next_state = `PRRO_ST_DELAY;
          end
        end
      end
      `PRRO_ST_DELAY: begin
        if (tick) begin
          next_elapsed = elapsed + 10'd1;
          if (elapsed + 10'd1 >= output_delay_setting) begin
            next_active = 1'b1;
            next_state  = `PRRO_ST_ACTIVE;
          end
        end
      end
      `PRRO_ST_ACTIVE: begin
        if (is_ready && tick) begin
          next_state = `PRRO_ST_HOLD;
        end
      end
      `PRRO_ST_HOLD: begin
        if (tick) begin
          next_active = 1'b0;
          next_state  = `PRRO_ST_IDLE;
        end
      end
      default: begin
        next_state = `PRRO_ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state   <= `PRRO_ST_IDLE;
      elapsed <= {`PRRO_DELAY_W{1'b0}};
      active  <= 1'b0;
    end else if (ce) begin
      if (!timed) begin
        state   <= `PRRO_ST_IDLE;
        elapsed <= {`PRRO_DELAY_W{1'b0}};
        active  <= 1'b0;
      end else begin
        state   <= next_state;
        elapsed <= next_elapsed;
        active  <= next_active;
      end
    end
  end

  always @* begin
    level = timed ? next_active : state_level;
  end

  always @(posedge clock) begin
    if (rst) begin
      relay_out <= 1'b0;
    end else if (ce) begin
      relay_out <= level ^ invert;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      output_function_select <= `PRRO_SEL_RESET;
      output_delay_setting   <= `PRRO_DELAY_RESET;
      reject                 <= 1'b0;
      wb_ack_o               <= 1'b0;
      wb_dat_o               <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= access;
      wb_dat_o <= 32'h0000_0000;
      if (access && wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          `PRRO_ADDR_CTRL: begin
            if (wb_dat_i[31:`PRRO_SEL_W] == 27'h000_0000 && sel_in <= `PRRO_SEL_MAX) begin
              output_function_select <= sel_in;
              reject                 <= 1'b0;
            end else begin
              reject <= 1'b1;
            end
          end
          `PRRO_ADDR_DELAY: begin
            if (wb_sel_i[1] && wb_dat_i[31:`PRRO_DELAY_W] == 22'h00_0000 &&
                dly_in <= `PRRO_DELAY_MAX) begin
              output_delay_setting <= dly_in;
            end
          end
          default: begin
            reject <= reject;
          end
        endcase
      end
      if (access && !wb_we_i) begin
        case (wb_adr_i)
          `PRRO_ADDR_CTRL:    wb_dat_o <= {27'h000_0000, output_function_select};
          `PRRO_ADDR_DELAY:   wb_dat_o <= {22'h00_0000, output_delay_setting};
          `PRRO_ADDR_STATUS:  wb_dat_o <= {26'h000_0000, state, reject, timed, active,
                                           relay_out};
          `PRRO_ADDR_ELAPSED: wb_dat_o <= {22'h00_0000, elapsed};
          default:            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// >>> prro_contact.sv
// model of the relay contacts wired to the controller output
`timescale 1ns/10ps
module prro_contact #(
  parameter int SETTLE = 2
) (
  input  wire logic clock,
  input  wire logic relay_out,
  output logic      contact_closed
);
  logic [7:0] age = 8'h00;
  initial contact_closed = 1'b0;
  // contacts settle a few cycles after the coil drive changes
  always @(posedge clock) begin
    age <= (relay_out == contact_closed) ? 8'h00 : age + 8'h01;
    if (age >= SETTLE) contact_closed <= relay_out;
  end
endmodule

// >>> prro_top_asserts.sv
// port checker for the relay output controller
`timescale 1ns/10ps
module prro_top_chk (
  input wire        clock,
  input wire        rst,
  input wire        ce,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire [3:0]  fault_code,
  input wire        fault_active,
  input wire        is_ready,
  input wire        is_starting,
  input wire        is_bypass,
  input wire        relay_out
);
  reg  [4:0] sel_m;
  reg  [9:0] dly_m;
  reg        ind;
  wire       take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  wire       rd = wb_ack_o && !wb_we_i;
  wire [4:0] item = (sel_m > 5'h09) ? sel_m - 5'h0A : sel_m;
  wire       mf = fault_active && (fault_code inside {4'h5, 4'h6, 4'h7, 4'h8, 4'hC, 4'hF});
  // mirror of the accepted settings
  always @(posedge clock) begin
    if (rst) begin
      sel_m <= 5'h07;
      dly_m <= 10'h000;
    end else if (take && wb_we_i) begin
      if (wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i <= 32'h0000_0013) sel_m <= wb_dat_i[4:0];
      if (wb_adr_i == 8'h04 && &wb_sel_i[1:0] && wb_dat_i <= 32'h0000_03E7)
        dly_m <= wb_dat_i[9:0];
    end
  end
  always @* begin
    case (item)
      5'h05:   ind = mf;
      5'h07:   ind = is_ready;
      5'h08:   ind = is_starting;
      default: ind = is_bypass;
    endcase
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ack_answer_a: assert property (take |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack too long");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("dat not 0");
  unmapped_zero_a: assert property (rd && !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C})
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read");
  ctrl_read_a: assert property (rd && wb_adr_i == 8'h00
    |-> wb_dat_o == {27'h000_0000, sel_m}) else $error("select read");
  delay_read_a: assert property (rd && wb_adr_i == 8'h04
    |-> wb_dat_o == {22'h00_0000, dly_m}) else $error("delay read");
  timed_flag_a: assert property (rd && wb_adr_i == 8'h08
    |-> wb_dat_o[2] == (item < 5'h05)) else $error("mode flag");
  state_follow_a: assert property (item > 5'h04 && item != 5'h06 && $past(sel_m) == sel_m
    |-> relay_out == ($past(ind) ^ (sel_m > 5'h09))) else $error("state relay");
endmodule
bind prro_top prro_top_chk chk (.clock(clock), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fault_code(fault_code),
  .fault_active(fault_active), .is_ready(is_ready), .is_starting(is_starting),
  .is_bypass(is_bypass), .relay_out(relay_out));

// >>> testbench.sv
// self-checking bench for the relay output controller
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t mismatch", $time); end end
module testbench;
  logic        clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, rly, fa = 0, contact;
  logic        rdy = 0, stg = 0, byp = 0, scmd = 0, stp = 0, sdn = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  code = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, rd;
  logic [13:0] rows [9] = '{{5'h05, 4'h5, 5'h11}, {5'h05, 4'h4, 5'h10}, {5'h0F, 4'hC, 5'h10},
    {5'h06, 4'h0, 5'h01}, {5'h07, 4'h0, 5'h09}, {5'h11, 4'h0, 5'h08}, {5'h08, 4'h0, 5'h05},
    {5'h09, 4'h0, 5'h03}, {5'h13, 4'h0, 5'h01}};
  int          checks = 0, n_mismatch = 0;
  always #2.5 clock = ~clock;
  prro_top #(.TICK_CYCLES(28'd20)) uut (.clock(clock), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(rdat), .wb_ack_o(ack), .fault_code(code), .fault_active(fa), .is_ready(rdy),
    .is_starting(stg), .is_bypass(byp), .start_cmd(scmd), .stop_cmd(stp), .stop_done(sdn),
    .relay_out(rly));
  prro_contact ct (.clock(clock), .relay_out(rly), .contact_closed(contact));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clock); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic wait_rly(input logic v, input int n);
    repeat (n) if (rly !== v) @(posedge clock);
    `CHK(rly, v)
  endtask
  task automatic idle_in;
    {code, fa, rdy, stg, byp, scmd, stp, sdn} <= 11'h000;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 0;
    bus(1, 8'h04, 32'h0000_03E7);
    bus(1, 8'h04, 32'h0000_03E8);
    bus(0, 8'h04, 0);
    `CHK(rd, 32'h0000_03E7)
    foreach (rows[i]) begin
      bus(1, 8'h00, {27'h000_0000, rows[i][13:9]});
      {code, fa, rdy, stg, byp} <= rows[i][8:1];
      repeat (3) @(posedge clock);
      `CHK(rly, rows[i][0])
    end
    $display("state table done");
    bus(1, 8'h00, 32'h0000_0014);
    bus(0, 8'h00, 0);
    `CHK(rd, 32'h0000_0013)
    bus(0, 8'h08, 0);
    `CHK(rd[3], 1'b1)
    bus(0, 8'h10, 0);
    `CHK(rd, 32'h0000_0000)
    bus(1, 8'h04, 0);
    for (int e = 0; e < 5; e++) begin
      bus(1, 8'h00, 32'h0000_0007);
      idle_in();
      bus(1, 8'h00, e);
      repeat (3) @(posedge clock);
      `CHK(rly, 1'b0)
      {sdn, stp, byp, stg, scmd} <= 5'h01 << e;
      wait_rly(1'b1, 4);
    end
    bus(1, 8'h00, 32'h0000_0007);
    bus(1, 8'h00, 32'h0000_000A);
    repeat (3) @(posedge clock);
    `CHK(rly, 1'b1)
    $display("events done");
    bus(1, 8'h00, 32'h0000_0007);
    idle_in();
    bus(1, 8'h04, 32'h0000_0003);
    bus(1, 8'h00, 0);
    scmd <= 1;
    repeat (55) @(posedge clock);
    `CHK(rly, 1'b0)
    wait_rly(1'b1, 10);
    rdy <= 1;
    repeat (35) @(posedge clock);
    `CHK(rly, 1'b1)
    `CHK(contact, 1'b1)
    wait_rly(1'b0, 50);
    idle_in();
    bus(1, 8'h00, 32'h0000_0007);
    bus(1, 8'h00, 0);
    scmd <= 1;
    repeat (40) @(posedge clock);
    scmd <= 0;
    @(posedge clock);
    scmd <= 1;
    repeat (55) @(posedge clock);
    `CHK(rly, 1'b0)
    wait_rly(1'b1, 10);
    bus(0, 8'h0C, 0);
    `CHK(rd, 32'h0000_0003)
    $display("delay done");
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    bus(0, 8'h00, 0);
    `CHK(rd, 32'h0000_0007)
    bus(0, 8'h04, 0);
    `CHK(rd, 32'h0000_0000)
    bus(0, 8'h0C, 0);
    `CHK(rd, 32'h0000_0000)
    $display("reset done");
    end_of_test();
  end
endmodule
